/* File: logic/ipm_pkg.sv */
// Constants, register map and types shared by the interrupt and power mode controller
package ipm_pkg;

    // ************************************************************
    // Register bus map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] IPM_MISC_ADDR = 8'h20;
    localparam logic [7:0] IPM_STAT_ADDR = 8'h24;
    localparam logic [7:0] IPM_MISC_RST = 8'h00;

    // Field positions of misc_control
    localparam int IPM_UPOL_HI = 7;
    localparam int IPM_UPOL_LO = 6;
    localparam int IPM_CLKOUT_BIT = 5;
    localparam int IPM_LPOL_HI = 4;
    localparam int IPM_LPOL_LO = 3;
    localparam int IPM_PSM_HI = 2;
    localparam int IPM_PSM_LO = 1;
    localparam int IPM_SMS_BIT = 0;

    // Polarity encodings, upper bit first
    localparam logic [1:0] IPM_POL_FALL_LOW = 2'h0;
    localparam logic [1:0] IPM_POL_FALL = 2'h2;
    localparam logic [1:0] IPM_POL_RISE = 2'h1;
    localparam logic [1:0] IPM_POL_BOTH = 2'h3;

    // ************************************************************
    // Interrupt sources, highest priority at index 0
    // ************************************************************
    localparam int IPM_NSRC = 10;
    localparam int IPM_NEXT = 4;
    localparam int IPM_NPER = 4;
    localparam int IPM_SRC_RESET = 0;
    localparam int IPM_SRC_TRAP = 1;
    localparam int IPM_SRC_EXT0 = 2;
    localparam int IPM_SRC_PER0 = 6;
    localparam logic [15:0] IPM_VEC [IPM_NSRC] = '{
        16'hfffe, 16'hfffc, 16'hfff6, 16'hfff4, 16'hfff2,
        16'hfff0, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6};
    // Sources that may leave halt: reset and external line 2
    localparam logic [IPM_NSRC-1:0] IPM_HALT_WAKE = 10'h011;
    localparam logic [IPM_NSRC-1:0] IPM_MASKABLE = 10'h3fc;

    // ************************************************************
    // Clock divider terminal counts (period minus one)
    // ************************************************************
    localparam int IPM_DIV_W = 5;
    localparam logic [IPM_DIV_W-1:0] IPM_DIV_NORMAL = 5'h01;
    localparam logic [IPM_DIV_W-1:0] IPM_SLOW_TERM [4] = '{5'h03, 5'h0f, 5'h07, 5'h1f};

    // Oscillator stabilisation, in processor clock cycles
    localparam int IPM_STAB_CYCLES = 4096;
    localparam int IPM_STAB_W = 13;

    typedef enum logic [1:0] {ipm_run, ipm_wait, ipm_halt, ipm_stab} ipm_mode_t;

endpackage

/* File: logic/ipm_clk_div.sv */
// Oscillator prescaler giving the processor clock enable and its waveform
`timescale 1ns/100ps
module ipm_clk_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic [1:0] psm_i,
    // Outputs
    output logic tick_o,
    output logic level_o
);
    logic [ipm_pkg::IPM_DIV_W-1:0] cnt;
    logic lvl;
    wire logic [ipm_pkg::IPM_DIV_W-1:0] term;
    wire logic [ipm_pkg::IPM_DIV_W-1:0] next_cnt;

    assign term = slow_i ? ipm_pkg::IPM_SLOW_TERM[psm_i] : ipm_pkg::IPM_DIV_NORMAL;
    // Wrap also when a new setting leaves the count above the terminal
    assign tick_o = run_i && (cnt >= term);
    assign next_cnt = tick_o ? '0 : (run_i ? cnt + 1'b1 : cnt);
    assign level_o = lvl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            lvl <= 1'b0;
        end else begin
            cnt <= next_cnt;
            lvl <= run_i && (next_cnt <= (term >> 1));
        end
    end

    normal_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o && !slow_i ##1 !slow_i && run_i ##1 !slow_i && run_i |-> tick_o && !$past(tick_o))
        else $error("normal mode clock is not oscillator over two");
endmodule

/* File: logic/ipm_ext_det.sv */
// Edge and level detector with request latch for one external interrupt line
`timescale 1ns/100ps
module ipm_ext_det (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Line and control
    input wire logic line_i,
    input wire logic [1:0] pol_i,
    input wire logic pol_chg_i,
    input wire logic ack_i,
    // Request
    output logic pend_o
);
    logic prev;
    logic latch;
    wire logic fell;
    wire logic rose;
    wire logic set_req;
    wire logic level_req;

    assign fell = prev && !line_i;
    assign rose = !prev && line_i;
    assign set_req = (fell && (pol_i != ipm_pkg::IPM_POL_RISE)) ||
                     (rose && (pol_i[0] == 1'b1));
    assign level_req = (pol_i == ipm_pkg::IPM_POL_FALL_LOW) && !line_i;
    assign pend_o = latch || level_req;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b1;
            latch <= 1'b0;
        end else begin
            prev <= line_i;
            // New edge wins over the clear of the same cycle
            latch <= set_req || (latch && !ack_i && !pol_chg_i);
        end
    end

    rise_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rose && pol_i == 2'h1 |=> pend_o)
        else $error("rising edge missed in rising mode");
    fall_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !latch && pol_i == 2'h2 && !fell ##1 !set_req |-> !latch)
        else $error("latch set without falling edge");
    pol_discard_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pol_chg_i && !set_req |=> !latch)
        else $error("request kept across polarity change");
endmodule

/* File: logic/ipm_top.sv */
// Interrupt vectoring, power saving modes and misc_control register
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps

module ipm_top #(
    parameter int STAB_CYCLES = ipm_pkg::IPM_STAB_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Processor core
    input wire logic trap_i,
    input wire logic wait_instruction_i,
    input wire logic halt_instruction_i,
    input wire logic i_bit_i,
    input wire logic int_ack_i,
    output logic irq_o,
    output logic [15:0] vector_o,
    output logic i_mask_clear_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    // Oscillator and watchdog
    input wire logic watchdog_en_i,
    output logic osc_on_o,
    output logic wdg_reset_o,
    // Interrupt sources
    input wire logic [3:0] ext_line_i,
    input wire logic [3:0] periph_irq_i,
    // Port F pin 0 alternate function
    output logic port_f_pin_0_o,
    output logic port_f_pin_0_oe_o
);

    // ************************************************************
    // State
    // ************************************************************
    localparam int IPM_STAB_W_L = ipm_pkg::IPM_STAB_W;
    localparam logic [IPM_STAB_W_L-1:0] STAB_LAST = IPM_STAB_W_L'(STAB_CYCLES - 1);
    wire logic [ipm_pkg::IPM_NEXT-1:0] ext_pend;
    ipm_pkg::ipm_mode_t mode;
    ipm_pkg::ipm_mode_t next_mode;
    logic [7:0] misc_control;
    logic [IPM_STAB_W_L-1:0] stab_cnt;
    logic reset_pend;
    logic trap_pend;
    logic irq;
    logic [15:0] vector;
    logic [ipm_pkg::IPM_NSRC-1:0] sel_q;
    logic ack;
    logic [31:0] rd_data;
    logic mask_clr;
    logic wdg_fire;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    wire logic bus_req = wb_cyc_i && wb_stb_i;
    wire logic hit_misc = (wb_adr_i == ipm_pkg::IPM_MISC_ADDR);
    wire logic hit_stat = (wb_adr_i == ipm_pkg::IPM_STAT_ADDR);
    // Write lands on the edge where the master sees ack
    wire logic misc_wr = bus_req && wb_we_i && ack && wb_sel_i[0] && hit_misc;
    wire logic [7:0] wr_byte = wb_dat_i[7:0];
    wire logic upol_chg = misc_wr &&
        (wr_byte[ipm_pkg::IPM_UPOL_HI:ipm_pkg::IPM_UPOL_LO] !=
         misc_control[ipm_pkg::IPM_UPOL_HI:ipm_pkg::IPM_UPOL_LO]);
    wire logic lpol_chg = misc_wr &&
        (wr_byte[ipm_pkg::IPM_LPOL_HI:ipm_pkg::IPM_LPOL_LO] !=
         misc_control[ipm_pkg::IPM_LPOL_HI:ipm_pkg::IPM_LPOL_LO]);
    // Status view: line requests, trap, reset, then mode
    wire logic [7:0] stat_byte = {ext_pend, trap_pend, reset_pend, mode};
    wire logic [31:0] rd_mux = hit_misc ? {24'h000000, misc_control} :
                               hit_stat ? {24'h000000, stat_byte} : 32'h00000000;

    assign wb_ack_o = ack;
    assign wb_dat_o = rd_data;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rd_data <= 32'h00000000;
        end else begin
            ack <= bus_req && !ack;
            rd_data <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        // Watchdog reset returns the register to its reset value
        if (rst_i || wdg_fire) begin
            misc_control <= ipm_pkg::IPM_MISC_RST;
        end else if (misc_wr) begin
            misc_control <= wr_byte;
        end
    end

    // ************************************************************
    // Clocking
    // ************************************************************
    wire logic cpu_tick;
    wire logic cpu_level;
    wire logic osc_run = (mode != ipm_pkg::ipm_halt);

    ipm_clk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(osc_run),
        .slow_i(misc_control[ipm_pkg::IPM_SMS_BIT]),
        .psm_i(misc_control[ipm_pkg::IPM_PSM_HI:ipm_pkg::IPM_PSM_LO]),
        .tick_o(cpu_tick),
        .level_o(cpu_level)
    );

    assign osc_on_o = osc_run;
    assign cpu_clk_en_o = cpu_tick && (mode == ipm_pkg::ipm_run);
    assign periph_clk_en_o = cpu_tick && (mode != ipm_pkg::ipm_stab);
    assign port_f_pin_0_oe_o = misc_control[ipm_pkg::IPM_CLKOUT_BIT];
    assign port_f_pin_0_o = cpu_level && misc_control[ipm_pkg::IPM_CLKOUT_BIT];

    // ************************************************************
    // External line detectors
    // ************************************************************
    // Only the source whose vector is on offer is cleared
    wire logic [ipm_pkg::IPM_NSRC-1:0] ack_sel = sel_q & {ipm_pkg::IPM_NSRC{int_ack_i}};

    genvar g;
    generate
        for (g = 0; g < ipm_pkg::IPM_NEXT; g++) begin : g_ext
            // Lines 2 and 3 share the upper field, 0 and 1 the lower
            wire logic [1:0] pol = (g >= 2) ?
                misc_control[ipm_pkg::IPM_UPOL_HI:ipm_pkg::IPM_UPOL_LO] :
                misc_control[ipm_pkg::IPM_LPOL_HI:ipm_pkg::IPM_LPOL_LO];
            ipm_ext_det u_det (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .line_i(ext_line_i[g]),
                .pol_i(pol),
                .pol_chg_i((g >= 2) ? upol_chg : lpol_chg),
                .ack_i(ack_sel[ipm_pkg::IPM_SRC_EXT0 + g]),
                .pend_o(ext_pend[g])
            );
        end
    endgenerate

    // ************************************************************
    // Priority and vector
    // ************************************************************
    wire logic [ipm_pkg::IPM_NSRC-1:0] req_raw = {periph_irq_i, ext_pend, trap_pend, reset_pend};
    wire logic [ipm_pkg::IPM_NSRC-1:0] req_m = req_raw &
        ~(ipm_pkg::IPM_MASKABLE & {ipm_pkg::IPM_NSRC{i_bit_i}});
    wire logic [ipm_pkg::IPM_NSRC:0] higher;
    wire logic [ipm_pkg::IPM_NSRC-1:0] sel;
    wire logic [15:0] vec_or [ipm_pkg::IPM_NSRC+1];

    assign higher[0] = 1'b0;
    assign vec_or[0] = 16'h0000;
    generate
        for (g = 0; g < ipm_pkg::IPM_NSRC; g++) begin : g_prio
            assign sel[g] = req_m[g] && !higher[g];
            assign higher[g+1] = higher[g] || req_m[g];
            assign vec_or[g+1] = vec_or[g] | (sel[g] ? ipm_pkg::IPM_VEC[g] : 16'h0000);
        end
    endgenerate

    // Vectors only offered while the processor runs
    wire logic next_irq = (mode == ipm_pkg::ipm_run) && higher[ipm_pkg::IPM_NSRC];
    assign irq_o = irq;
    assign vector_o = vector;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq <= 1'b0;
            vector <= 16'h0000;
            sel_q <= '0;
        end else begin
            irq <= next_irq;
            vector <= vec_or[ipm_pkg::IPM_NSRC];
            sel_q <= next_irq ? sel : '0;
        end
    end

    // ************************************************************
    // Reset and trap requests
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_pend <= 1'b1;
            trap_pend <= 1'b0;
        end else begin
            reset_pend <= wdg_fire || (reset_pend && !ack_sel[ipm_pkg::IPM_SRC_RESET]);
            trap_pend <= trap_i || (trap_pend && !ack_sel[ipm_pkg::IPM_SRC_TRAP]);
        end
    end

    // ************************************************************
    // Power mode sequencer
    // ************************************************************
    wire logic halt_req = (mode == ipm_pkg::ipm_run) && halt_instruction_i;
    wire logic wait_req = (mode == ipm_pkg::ipm_run) && wait_instruction_i;
    wire logic stab_done = cpu_tick && (stab_cnt == STAB_LAST);
    // Reset request and line 2 both wake from halt; rst_i forces stabilisation by itself
    wire logic halt_wake = |(req_raw & ipm_pkg::IPM_HALT_WAKE);

    always_comb begin
        next_mode = mode;
        unique case (mode)
            ipm_pkg::ipm_run: begin
                if (halt_req && watchdog_en_i) begin
                    next_mode = ipm_pkg::ipm_stab;
                end else if (halt_req) begin
                    next_mode = ipm_pkg::ipm_halt;
                end else if (wait_req) begin
                    next_mode = ipm_pkg::ipm_wait;
                end
            end
            ipm_pkg::ipm_wait: begin
                if (|req_raw) begin
                    next_mode = ipm_pkg::ipm_run;
                end
            end
            ipm_pkg::ipm_halt: begin
                if (halt_wake) begin
                    next_mode = ipm_pkg::ipm_stab;
                end
            end
            ipm_pkg::ipm_stab: begin
                if (stab_done) begin
                    next_mode = ipm_pkg::ipm_run;
                end
            end
        endcase
    end

    assign i_mask_clear_o = mask_clr;
    assign wdg_reset_o = wdg_fire;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Leaving reset passes through the oscillator delay like a halt exit
            mode <= ipm_pkg::ipm_stab;
            stab_cnt <= '0;
            mask_clr <= 1'b0;
            wdg_fire <= 1'b0;
        end else begin
            mode <= next_mode;
            // Counts processor clocks, so slow settings lengthen it
            stab_cnt <= (mode != ipm_pkg::ipm_stab || stab_done) ? '0 :
                        (cpu_tick ? stab_cnt + 1'b1 : stab_cnt);
            mask_clr <= wait_req || (halt_req && !watchdog_en_i);
            wdg_fire <= halt_req && watchdog_en_i;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ext0_vec_a: assert property (mode == ipm_pkg::ipm_run && req_m[2] && !(|req_m[1:0])
        |=> irq_o && vector_o == 16'hfff6) else $error("line 0 vector wrong");
    ext1_vec_a: assert property (mode == ipm_pkg::ipm_run && req_m[3] && !(|req_m[2:0])
        |=> irq_o && vector_o == 16'hfff4) else $error("line 1 vector wrong");
    ext2_vec_a: assert property (mode == ipm_pkg::ipm_run && req_m[4] && !(|req_m[3:0])
        |=> irq_o && vector_o == 16'hfff2) else $error("line 2 vector wrong");
    ext3_vec_a: assert property (mode == ipm_pkg::ipm_run && req_m[5] && !(|req_m[4:0])
        |=> irq_o && vector_o == 16'hfff0) else $error("line 3 vector wrong");
    reset_vec_a: assert property (mode == ipm_pkg::ipm_run && reset_pend
        |=> irq_o && vector_o == 16'hfffe) else $error("reset vector not served");
    prio_trap_a: assert property (mode == ipm_pkg::ipm_run && trap_pend && !reset_pend
        |=> vector_o == 16'hfffc) else $error("trap lost priority");
    wait_stop_a: assert property (mode == ipm_pkg::ipm_wait
        |-> !cpu_clk_en_o && periph_clk_en_o == cpu_tick) else $error("wait clocking wrong");
    wait_exit_a: assert property (mode == ipm_pkg::ipm_wait && |req_raw
        |=> mode == ipm_pkg::ipm_run) else $error("wait not left on request");
    halt_off_a: assert property (mode == ipm_pkg::ipm_halt
        |-> !osc_on_o && !periph_clk_en_o) else $error("clock running in halt");
    halt_wdg_a: assert property (halt_req && watchdog_en_i
        |=> wdg_reset_o && mode == ipm_pkg::ipm_stab ##1 reset_pend)
        else $error("halt with watchdog did not reset");
    halt_mask_a: assert property ($rose(mode == ipm_pkg::ipm_halt) |-> i_mask_clear_o)
        else $error("mask bit not cleared on halt");
    stab_len_a: assert property ($rose(mode == ipm_pkg::ipm_run) &&
        $past(mode) == ipm_pkg::ipm_stab |-> $past(stab_cnt) == STAB_LAST)
        else $error("stabilisation length wrong");
    stab_hold_a: assert property (mode == ipm_pkg::ipm_stab |-> !cpu_clk_en_o && !irq)
        else $error("processor released during stabilisation");
    misc_rst_a: assert property ($fell(rst_i) |-> misc_control == 8'h00)
        else $error("misc_control reset value wrong");
    clk_out_a: assert property (!port_f_pin_0_oe_o |-> !port_f_pin_0_o)
        else $error("port F pin 0 driven while disabled");
    bus_ack_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    misc_write_a: assert property (misc_wr && !wdg_fire
        |=> misc_control == $past(wr_byte)) else $error("misc_control write lost");
    run_clk_a: assert property (mode == ipm_pkg::ipm_run
        |-> cpu_clk_en_o == periph_clk_en_o) else $error("run clocks differ");
    wait_entry_a: assert property (wait_req && !halt_instruction_i
        |=> mode == ipm_pkg::ipm_wait && i_mask_clear_o) else $error("wait not entered");
    halt_exit_a: assert property (mode == ipm_pkg::ipm_halt && halt_wake
        |=> mode == ipm_pkg::ipm_stab) else $error("halt not left on wake request");
    halt_stay_a: assert property (mode == ipm_pkg::ipm_halt && !halt_wake
        |=> mode == ipm_pkg::ipm_halt) else $error("halt left without wake request");
    clk_out_on_a: assert property (port_f_pin_0_oe_o
        |-> port_f_pin_0_o == cpu_level) else $error("port F pin 0 not showing clock");

    wait_seen_c: cover property (mode == ipm_pkg::ipm_wait ##[1:20] mode == ipm_pkg::ipm_run);
    halt_wake_c: cover property (mode == ipm_pkg::ipm_halt ##1 mode == ipm_pkg::ipm_stab);
    wdg_fire_c: cover property (wdg_reset_o);
    ext2_taken_c: cover property (irq_o && vector_o == 16'hfff2 && int_ack_i);
    slow_tick_c: cover property (misc_control[ipm_pkg::IPM_SMS_BIT] && cpu_tick);

endmodule

/* File: tb/ipm_core_model.sv */
// Processor core partner that takes every interrupt the controller offers
`timescale 1ns/100ps
module ipm_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side
    input wire logic irq_i,
    input wire logic [15:0] vector_i,
    output logic int_ack_o,
    output logic [15:0] taken_o
);
    logic [1:0] gap;
    // Three idle cycles between acks: irq is registered and drops late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_ack_o <= 1'b0;
            gap <= 2'h0;
            taken_o <= 16'h0000;
        end else if (irq_i && !int_ack_o && gap == 2'h0) begin
            int_ack_o <= 1'b1;
            gap <= 2'h3;
        end else begin
            int_ack_o <= 1'b0;
            gap <= (gap != 2'h0) ? gap - 2'h1 : gap;
            // Vector is the one on offer while the ack stands
            if (int_ack_o) begin
                taken_o <= vector_i;
            end
        end
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the interrupt and power mode controller
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, trap = 1'b0, wait_instruction = 1'b0, hlt = 1'b0;
    logic ibit = 1'b0, wdg_en = 1'b0, ack, irq, mclr, cpu_en, per_en, osc, wdg, ack_in, pf, pf_oe;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [3:0] ext = 4'hf, per = 4'h0, sel = 4'h0, lane = 4'h1;
    logic [15:0] vec, taken;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int rises = 0;
    always #25 clk = ~clk;
    ipm_top #(.STAB_CYCLES(8)) u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .trap_i(trap), .wait_instruction_i(wait_instruction), .halt_instruction_i(hlt),
        .i_bit_i(ibit), .int_ack_i(ack_in), .irq_o(irq), .vector_o(vec), .i_mask_clear_o(mclr),
        .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .watchdog_en_i(wdg_en),
        .osc_on_o(osc), .wdg_reset_o(wdg), .ext_line_i(ext), .periph_irq_i(per),
        .port_f_pin_0_o(pf), .port_f_pin_0_oe_o(pf_oe));
    ipm_core_model u_core (.clk_i(clk), .rst_i(rst), .irq_i(irq), .vector_i(vec),
        .int_ack_o(ack_in), .taken_o(taken));

    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Ceiling well above the less than one thousand cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lane;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, ipm_pkg::IPM_MISC_ADDR, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk("read data", q, exp);
    endtask
    // Irq must rise no sooner than lo and before hi cycles, carrying vector v
    task automatic wait_irq(input int lo, input int hi, input logic [15:0] v);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < hi) begin
            @(posedge clk);
            n++;
        end
        chk("irq delay", 32'(n >= lo && n < hi), 32'h1);
        chk("vector", {16'h0, vec}, {16'h0, v});
    endtask
    task automatic see(ref logic s, input int n, input string what);
        int hit;
        hit = 0;
        repeat (n) begin
            @(posedge clk);
            hit = hit | (s === 1'b1);
        end
        chk(what, 32'(hit), 32'h1);
    endtask
    task automatic count(input int n, output int c, output int p);
        logic last;
        c = 0;
        p = 0;
        rises = 0;
        last = pf;
        repeat (n) begin
            @(posedge clk);
            c = c + (cpu_en === 1'b1);
            p = p + (per_en === 1'b1);
            rises = rises + (pf === 1'b1 && last === 1'b0);
            last = pf;
        end
    endtask

    task automatic t_regs;
        rd(ipm_pkg::IPM_MISC_ADDR, 32'h0);
        wr(8'ha5);
        rd(ipm_pkg::IPM_MISC_ADDR, 32'ha5);
        chk("clock out enable", pf_oe, 1'b1);
        rd(8'h30, 32'h0);
        wr(8'h00);
        chk("clock out enable", pf_oe, 1'b0);
        lane = 4'h0;
        wr(8'h3c);
        lane = 4'h1;
        rd(ipm_pkg::IPM_MISC_ADDR, 32'h0);
    endtask
    task automatic t_ext;
        logic [15:0] v [4] = '{16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0};
        for (int i = 0; i < 4; i++) begin
            ext[i] <= 1'b0;
            wait_irq(1, 6, v[i]);
            ext[i] <= 1'b1;
            step(6);
            chk("irq released", irq, 1'b0);
            chk("taken vector", {16'h0, taken}, {16'h0, v[i]});
        end
    endtask
    task automatic t_prio;
        logic [15:0] v [4] = '{16'hffec, 16'hffea, 16'hffe8, 16'hffe6};
        trap <= 1'b1;
        step(1);
        trap <= 1'b0;
        per <= 4'hf;
        wait_irq(1, 6, 16'hfffc);
        for (int k = 0; k < 4; k++) begin
            step(4);
            chk("vector", {16'h0, vec}, {16'h0, v[k]});
            per[k] <= 1'b0;
        end
        step(4);
    endtask
    task automatic t_pol;
        ibit <= 1'b1;
        wr(8'h10);
        ext[0] <= 1'b0;
        step(1);
        ext[0] <= 1'b1;
        step(2);
        wr(8'h18);
        ibit <= 1'b0;
        step(6);
        chk("dropped request", irq, 1'b0);
        ext[0] <= 1'b0;
        wait_irq(1, 6, 16'hfff6);
        ext[0] <= 1'b1;
        step(6);
        wr(8'h40);
        ext[3] <= 1'b0;
        step(5);
        chk("falling ignored", irq, 1'b0);
        ext[3] <= 1'b1;
        wait_irq(1, 6, 16'hfff0);
        step(6);
        wr(8'h00);
    endtask
    task automatic t_wait;
        int c, p;
        wait_instruction <= 1'b1;
        step(1);
        wait_instruction <= 1'b0;
        see(mclr, 3, "mask clear");
        rd(ipm_pkg::IPM_STAT_ADDR, 32'h1);
        count(16, c, p);
        chk("cpu ticks", c, 0);
        chk("periph ticks", p, 8);
        per[0] <= 1'b1;
        wait_irq(1, 8, 16'hffec);
        per[0] <= 1'b0;
        step(6);
    endtask
    task automatic t_halt;
        int c, p;
        hlt <= 1'b1;
        step(1);
        hlt <= 1'b0;
        see(mclr, 3, "mask clear");
        chk("oscillator", osc, 1'b0);
        per[1] <= 1'b1;
        count(16, c, p);
        chk("periph ticks", p, 0);
        chk("oscillator", osc, 1'b0);
        per[1] <= 1'b0;
        ext[2] <= 1'b0;
        step(2);
        ext[2] <= 1'b1;
        wait_irq(14, 40, 16'hfff2);
        step(6);
        chk("taken vector", {16'h0, taken}, 32'hfff2);
    endtask
    task automatic t_wdg;
        wr(8'h21);
        wdg_en <= 1'b1;
        hlt <= 1'b1;
        step(1);
        hlt <= 1'b0;
        see(wdg, 3, "watchdog reset");
        chk("oscillator", osc, 1'b1);
        wdg_en <= 1'b0;
        wait_irq(10, 40, 16'hfffe);
        step(4);
        rd(ipm_pkg::IPM_MISC_ADDR, 32'h0);
    endtask
    task automatic t_clk;
        logic [7:0] cfg [5] = '{8'h20, 8'h21, 8'h23, 8'h25, 8'h27};
        int exp [5] = '{32, 16, 4, 8, 2};
        int c, p;
        for (int i = 0; i < 5; i++) begin
            wr(cfg[i]);
            step(40);
            count(64, c, p);
            chk("cpu ticks", c, exp[i]);
            chk("periph ticks", p, exp[i]);
            chk("clock out edges", rises, exp[i]);
            chk("clock out enable", pf_oe, 1'b1);
        end
        wr(8'h00);
    endtask

    initial begin
        step(6);
        rst <= 1'b0;
        wait_irq(14, 40, 16'hfffe);
        chk("oscillator", osc, 1'b1);
        step(6);
        t_regs();
        t_ext();
        t_prio();
        t_pol();
        t_wait();
        t_halt();
        t_wdg();
        t_clk();
        complete_run();
    end
endmodule
